// *** inc/cmo_pkg.sv ***
// Purpose: shared constants and types for the comparator and memory operators
// Assumes: 100 MHz system clock
// Notes:   timing, limit and reset figures named here; port widths and SIG_BITS' four bits are literals in the logic

package cmo_pkg;

   //------------------------------------------------------------------
   // clock and timing
   //------------------------------------------------------------------
   localparam int CLK_HZ            = 100_000_000;
   localparam int NV_WRITE_MS       = 50;        // longest nv store
   localparam int NV_WRITE_CYCLES   = NV_WRITE_MS * (CLK_HZ / 1000);
   localparam int BLINK_HZ          = 1;         // restart request blink
   localparam int BLINK_HALF_CYCLES = CLK_HZ / (2 * BLINK_HZ);

   //------------------------------------------------------------------
   // sizes and limits
   //------------------------------------------------------------------
   localparam int CMP_MAX_BITS   = 8;
   localparam int CMP_MIN_BITS   = 2;
   localparam int SIG_BITS       = 4;
   localparam int MAX_STORED_SR  = 8;
   localparam int NV_WRITE_LIMIT = 100000;
   localparam int NV_CNT_W       = 17;

   //------------------------------------------------------------------
   // reset values
   //------------------------------------------------------------------
   localparam logic OUT_RST   = 1'h0;
   localparam logic BLINK_RST = 1'h0;

   //------------------------------------------------------------------
   // relation selection and nv write states
   //------------------------------------------------------------------
   typedef enum logic [2:0] {
      CMO_LT, CMO_LE, CMO_GT, CMO_GE, CMO_EQ, CMO_NE
   } cmo_rel_e;

   typedef enum logic [0:0] {
      CMO_NV_IDLE, CMO_NV_BUSY
   } cmo_nv_state_e;

endpackage

// *** rtl/cmo_restart_latch.sv ***
// Purpose: restart latch, manual or monitored, with both request outputs
// Assumes: inputs synchronous to clk_sys; blink_phase from the top
// Notes:   MONITORED selects a low-high-low restart pulse

`timescale 1ns/1ps

module cmo_restart_latch #(
   parameter bit MONITORED = 1'b0
) (
   // clock and reset
   input  wire logic clk_sys,
   input  wire logic rst_b,
   // latch inputs
   input  wire logic clear_en,
   input  wire logic clear,
   input  wire logic permit,
   input  wire logic restart,
   input  wire logic blink_phase,
   // latch outputs
   output logic      q,
   output logic      req1,
   output logic      req2
);

   //------------------------------------------------------------------
   // restart conditions
   //------------------------------------------------------------------
   logic restart_prev_reg;
   logic armed_reg;
   logic clr;
   logic hold_ok;
   logic trigger;
   logic q_next;

   // clear absent acts as clear inactive
   assign clr     = clear_en & clear;
   assign hold_ok = ~clr & permit;
   assign trigger = MONITORED ?
                    (armed_reg & ~restart & restart_prev_reg) :
                    (restart & ~restart_prev_reg);
   // latch set, hold, or drop
   assign q_next  = ~hold_ok ? 1'h0 : (trigger ? 1'h1 : q);

   // previous restart level for edges
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         restart_prev_reg <= cmo_pkg::OUT_RST;
      end else begin
         restart_prev_reg <= restart;
      end
   end

   // monitored pulse arming
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         armed_reg <= cmo_pkg::OUT_RST;
      end else if (!hold_ok || !restart) begin
         armed_reg <= 1'h0;
      end else begin
         armed_reg <= 1'h1;
      end
   end

   //------------------------------------------------------------------
   // outputs
   //------------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         q    <= cmo_pkg::OUT_RST;
         req1 <= cmo_pkg::OUT_RST;
         req2 <= cmo_pkg::OUT_RST;
      end else begin
         q    <= q_next;
         req1 <= hold_ok & ~q_next;
         req2 <= ~hold_ok | (~q_next & blink_phase);
      end
   end

   //------------------------------------------------------------------
   // checks
   //------------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);

   a_latch_drop_low:
      assert property (!hold_ok |=> !q && !req1 && req2)
      else $error("latch not dropped by clear or permit");
   a_latch_hold_req:
      assert property (hold_ok && !trigger && !q |=> req1 && !q)
      else $error("request type 1 missing while waiting");
   a_latch_blink_req:
      assert property (hold_ok && !trigger && !q
                       |=> req2 == $past(blink_phase))
      else $error("request type 2 not following blink");
   a_latch_set_edge:
      assert property (hold_ok && trigger |=> q && !req1 && !req2)
      else $error("restart did not latch");
   a_latch_pulse:
      assert property (hold_ok && restart && !clr && permit
                       ##1 hold_ok && !restart |=> (MONITORED ? q : 1'h1))
      else $error("monitored pulse did not latch");

endmodule

// *** rtl/cmo_top.sv ***
// Purpose: comparator, d, t and sr flip-flops, restart latches
// Assumes: all inputs synchronous to clk_sys; nv memory answers on ack
// Notes:   outputs registered, one cycle after the inputs they reflect
//
// Notes on behaviour
// - constant mode compares two to eight masked bits with constant 0..255
// - bit 0 is least significant, highest used bit most significant
// - ordering relations true exactly while value meets relation to constant
// - equal true only on match, different only on mismatch
// - signal mode builds two four-bit operands, bit 0 least significant
// - signal mode output true exactly while a relates to b as selected
// - d flip-flop: preset alone sets, clear always clears, clear wins
// - d flip-flop loads data on capture rising edge, holds otherwise
// - t flip-flop inverts on toggle rising edge; optional clear zeroes it
// - sr flip-flop: set sets, reset or both clear, neither holds
// - stored sr outputs written to nv memory on change, restored at power-up
// - at most eight sr flip-flops keep state in nv memory
// - each nv write ends within 50 ms; worn flag raised at 100000 writes, writes go on
// - manual latch low on clear or low permit, else holds, sets on rise
// - type 1 request high only while waiting for restart
// - type 2 request high when blocked, blinks 1 Hz waiting, low latched
// - monitored latch behaves like manual except its restart condition
// - clear input exists only when enabled, else treated inactive

`timescale 1ns/1ps

module cmo_top #(
   parameter int SR_COUNT          = cmo_pkg::MAX_STORED_SR,
   parameter int NV_WRITE_CYCLES   = cmo_pkg::NV_WRITE_CYCLES,
   parameter int BLINK_HALF_CYCLES = cmo_pkg::BLINK_HALF_CYCLES
) (
   // clock and reset
   input  wire logic                  clk_sys,
   input  wire logic                  rst_b,
   // comparator
   input  wire logic [7:0]            cmp_bits,  // bit 0 first_bit
   input  wire logic [3:0]            cmp_count,
   input  wire logic [7:0]            cmp_const,
   input  wire cmo_pkg::cmo_rel_e     cmp_rel,
   input  wire logic                  cmp_signal_mode,
   input  wire logic [3:0]            operand_a, // bit 0 operand_a_first_bit
   input  wire logic [3:0]            operand_b, // bit 0 operand_b_first_bit
   output logic                       cmp_out,
   // d flip-flop
   input  wire logic                  dff_preset,
   input  wire logic                  dff_clear,
   input  wire logic                  dff_capture,
   input  wire logic                  dff_data,
   output logic                       dff_q,
   // t flip-flop
   input  wire logic                  tff_toggle,
   input  wire logic                  tff_clear_en,
   input  wire logic                  tff_clear,
   output logic                       tff_q,
   // sr flip-flops
   input  wire logic [SR_COUNT-1:0]   sr_set,
   input  wire logic [SR_COUNT-1:0]   sr_reset,
   input  wire logic [SR_COUNT-1:0]   sr_store_en,
   input  wire logic                  sr_restore_valid,
   input  wire logic [SR_COUNT-1:0]   sr_restore_data,
   output logic      [SR_COUNT-1:0]   sr_q,
   // nv memory port
   input  wire logic                  nv_wr_ack,
   output logic                       nv_wr_req,
   output logic      [SR_COUNT-1:0]   nv_wr_data,
   output logic                       nv_wr_timeout,
   output logic                       nv_wr_worn,
   // manual restart latch
   input  wire logic                  rm_clear_en,
   input  wire logic                  rm_clear,
   input  wire logic                  rm_permit,
   input  wire logic                  rm_restart,
   output logic                       rm_q,
   output logic                       rm_req1,
   output logic                       rm_req2,
   // monitored restart latch
   input  wire logic                  rmon_clear_en,
   input  wire logic                  rmon_clear,
   input  wire logic                  rmon_permit,
   input  wire logic                  rmon_restart,
   output logic                       rmon_q,
   output logic                       rmon_req1,
   output logic                       rmon_req2
);

   //------------------------------------------------------------------
   // elaboration checks
   //------------------------------------------------------------------
   if (SR_COUNT < 1 || SR_COUNT > cmo_pkg::MAX_STORED_SR) begin : g_bad_sr
      $error("SR_COUNT must lie in 1..MAX_STORED_SR");
   end
   if (NV_WRITE_CYCLES < 2 || BLINK_HALF_CYCLES < 2) begin : g_bad_time
      $error("timing counts must be at least 2");
   end

   localparam int NV_TW = $clog2(NV_WRITE_CYCLES);
   localparam int BL_W  = $clog2(BLINK_HALF_CYCLES);
   localparam logic [NV_TW-1:0] NV_LAST = NV_TW'(NV_WRITE_CYCLES - 1);
   localparam logic [BL_W-1:0]  BL_LAST = BL_W'(BLINK_HALF_CYCLES - 1);
   localparam logic [cmo_pkg::NV_CNT_W-1:0] NV_LIMIT =
      cmo_pkg::NV_CNT_W'(cmo_pkg::NV_WRITE_LIMIT);

   //------------------------------------------------------------------
   // decode helpers
   //------------------------------------------------------------------
   // relation between two unsigned values
   function automatic logic rel_true(input logic [7:0] a,
                                     input logic [7:0] b,
                                     input cmo_pkg::cmo_rel_e r);
      unique case (r)
         cmo_pkg::CMO_LT: rel_true = a <  b;
         cmo_pkg::CMO_LE: rel_true = a <= b;
         cmo_pkg::CMO_GT: rel_true = a >  b;
         cmo_pkg::CMO_GE: rel_true = a >= b;
         cmo_pkg::CMO_EQ: rel_true = a == b;
         cmo_pkg::CMO_NE: rel_true = a != b;
         default:         rel_true = 1'h0;
      endcase
   endfunction

   // mask of used inputs, count clamped to 2..8
   function automatic logic [7:0] used_mask(input logic [3:0] n);
      logic [3:0] k;
      k = n;
      if (n < 4'(cmo_pkg::CMP_MIN_BITS)) k = 4'(cmo_pkg::CMP_MIN_BITS);
      if (n > 4'(cmo_pkg::CMP_MAX_BITS)) k = 4'(cmo_pkg::CMP_MAX_BITS);
      used_mask = 8'(9'h1FF >> (4'h9 - k));
   endfunction

   //------------------------------------------------------------------
   // comparator
   //------------------------------------------------------------------
   logic [7:0] cmp_value;
   logic [7:0] sig_a;
   logic [7:0] sig_b;

   // unused upper inputs read as zero
   assign cmp_value = cmp_bits & used_mask(cmp_count);
   assign sig_a     = {4'h0, operand_a};
   assign sig_b     = {4'h0, operand_b};

   // relation result
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         cmp_out <= cmo_pkg::OUT_RST;
      end else if (cmp_signal_mode) begin
         cmp_out <= rel_true(sig_a, sig_b, cmp_rel);
      end else begin
         cmp_out <= rel_true(cmp_value, cmp_const, cmp_rel);
      end
   end

   //------------------------------------------------------------------
   // edge history
   //------------------------------------------------------------------
   logic dff_cap_prev_reg;
   logic tff_tog_prev_reg;

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         dff_cap_prev_reg <= cmo_pkg::OUT_RST;
         tff_tog_prev_reg <= cmo_pkg::OUT_RST;
      end else begin
         dff_cap_prev_reg <= dff_capture;
         tff_tog_prev_reg <= tff_toggle;
      end
   end

   //------------------------------------------------------------------
   // d and t flip-flops
   //------------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         dff_q <= cmo_pkg::OUT_RST;
      end else if (dff_clear) begin
         dff_q <= 1'h0;
      end else if (dff_preset) begin
         dff_q <= 1'h1;
      end else if (dff_capture && !dff_cap_prev_reg) begin
         dff_q <= dff_data;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         tff_q <= cmo_pkg::OUT_RST;
      end else if (tff_clear_en && tff_clear) begin
         tff_q <= 1'h0;
      end else if (tff_toggle && !tff_tog_prev_reg) begin
         tff_q <= ~tff_q;
      end
   end

   //------------------------------------------------------------------
   // sr flip-flops with optional nv restore
   //------------------------------------------------------------------
   logic restored_reg;
   logic restore_now;

   assign restore_now = sr_restore_valid & ~restored_reg;

   // power-up restore accepted once
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         restored_reg <= cmo_pkg::OUT_RST;
      end else if (sr_restore_valid) begin
         restored_reg <= 1'h1;
      end
   end

   for (genvar i = 0; i < SR_COUNT; i++) begin : g_sr
      always_ff @(posedge clk_sys or negedge rst_b) begin
         if (!rst_b) begin
            sr_q[i] <= cmo_pkg::OUT_RST;
         end else if (restore_now && sr_store_en[i]) begin
            sr_q[i] <= sr_restore_data[i];
         end else if (sr_reset[i]) begin
            sr_q[i] <= 1'h0;
         end else if (sr_set[i]) begin
            sr_q[i] <= 1'h1;
         end
      end
   end

   //------------------------------------------------------------------
   // nv store of changed sr state
   //------------------------------------------------------------------
   cmo_pkg::cmo_nv_state_e       nv_state_reg;
   logic [SR_COUNT-1:0]          sr_last_reg;
   logic                         restore_d_reg;
   logic                         dirty_reg;
   logic                         changed;
   logic                         launch;
   logic [NV_TW-1:0]             nv_timer_reg;
   logic [cmo_pkg::NV_CNT_W-1:0] nv_count_reg;

   assign changed = |((sr_q ^ sr_last_reg) & sr_store_en) & ~restore_d_reg;
   assign launch  = (nv_state_reg == cmo_pkg::CMO_NV_IDLE) & dirty_reg;

   // change history; a new change wins over the launch
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         sr_last_reg   <= '0;
         restore_d_reg <= cmo_pkg::OUT_RST;
         dirty_reg     <= cmo_pkg::OUT_RST;
      end else begin
         sr_last_reg   <= sr_q;
         restore_d_reg <= restore_now;
         if (changed) begin
            dirty_reg <= 1'h1;
         end else if (launch) begin
            dirty_reg <= 1'h0;
         end
      end
   end

   // one write in flight, abandoned after the longest store time
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         nv_state_reg  <= cmo_pkg::CMO_NV_IDLE;
         nv_wr_req     <= cmo_pkg::OUT_RST;
         nv_wr_data    <= '0;
         nv_timer_reg  <= '0;
         nv_wr_timeout <= cmo_pkg::OUT_RST;
      end else begin
         unique case (nv_state_reg)
            cmo_pkg::CMO_NV_IDLE: begin
               if (dirty_reg) begin
                  nv_state_reg <= cmo_pkg::CMO_NV_BUSY;
                  nv_wr_req    <= 1'h1;
                  nv_wr_data   <= sr_q & sr_store_en;
                  nv_timer_reg <= '0;
               end
            end
            cmo_pkg::CMO_NV_BUSY: begin
               nv_timer_reg <= nv_timer_reg + 1'b1;
               if (nv_wr_ack) begin
                  nv_state_reg <= cmo_pkg::CMO_NV_IDLE;
                  nv_wr_req    <= 1'h0;
               end else if (nv_timer_reg == NV_LAST) begin
                  nv_state_reg  <= cmo_pkg::CMO_NV_IDLE;
                  nv_wr_req     <= 1'h0;
                  nv_wr_timeout <= 1'h1;
               end
            end
         endcase
      end
   end

   // wear count; flags the write budget reached
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         nv_count_reg <= '0;
         nv_wr_worn   <= cmo_pkg::OUT_RST;
      end else if (launch) begin
         if (nv_count_reg != NV_LIMIT) begin
            nv_count_reg <= nv_count_reg + 1'b1;
         end
         nv_wr_worn <= (nv_count_reg + 1'b1) >= NV_LIMIT;
      end
   end

   //------------------------------------------------------------------
   // 1 Hz blink phase for type 2 requests
   //------------------------------------------------------------------
   logic [BL_W-1:0] blink_cnt_reg;
   logic            blink_phase_reg;

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         blink_cnt_reg   <= '0;
         blink_phase_reg <= cmo_pkg::BLINK_RST;
      end else if (blink_cnt_reg == BL_LAST) begin
         blink_cnt_reg   <= '0;
         blink_phase_reg <= ~blink_phase_reg;
      end else begin
         blink_cnt_reg <= blink_cnt_reg + 1'b1;
      end
   end

   //------------------------------------------------------------------
   // restart latches
   //------------------------------------------------------------------
   cmo_restart_latch #(.MONITORED(1'b0)) u_rst_manual (
      .clk_sys     (clk_sys),
      .rst_b       (rst_b),
      .clear_en    (rm_clear_en),
      .clear       (rm_clear),
      .permit      (rm_permit),
      .restart     (rm_restart),
      .blink_phase (blink_phase_reg),
      .q           (rm_q),
      .req1        (rm_req1),
      .req2        (rm_req2)
   );

   cmo_restart_latch #(.MONITORED(1'b1)) u_rst_monitor (
      .clk_sys     (clk_sys),
      .rst_b       (rst_b),
      .clear_en    (rmon_clear_en),
      .clear       (rmon_clear),
      .permit      (rmon_permit),
      .restart     (rmon_restart),
      .blink_phase (blink_phase_reg),
      .q           (rmon_q),
      .req1        (rmon_req1),
      .req2        (rmon_req2)
   );

   //------------------------------------------------------------------
   // checks
   //------------------------------------------------------------------
   // cycles the pending nv request has stood, for the time bound
   logic [NV_TW:0] nv_age_reg;

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         nv_age_reg <= '0;
      end else if (nv_wr_req) begin
         nv_age_reg <= nv_age_reg + 1'b1;
      end else begin
         nv_age_reg <= '0;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);

   a_cmp_less_const:
      assert property (!cmp_signal_mode && cmp_rel == cmo_pkg::CMO_LT
                       |=> cmp_out == ($past(cmp_value) < $past(cmp_const)))
      else $error("constant less relation wrong");
   a_cmp_equal_const:
      assert property (!cmp_signal_mode && cmp_rel == cmo_pkg::CMO_EQ
                       |=> cmp_out == ($past(cmp_bits & used_mask(cmp_count))
                                       == $past(cmp_const)))
      else $error("constant equal relation wrong");
   a_cmp_signal_ge:
      assert property (cmp_signal_mode && cmp_rel == cmo_pkg::CMO_GE
                       |=> cmp_out == ($past(operand_a) >= $past(operand_b)))
      else $error("signal relation wrong");
   a_dff_clear_wins:
      assert property (dff_clear && dff_preset |=> !dff_q)
      else $error("clear did not win over preset");
   a_dff_capture:
      assert property (!dff_clear && !dff_preset && $rose(dff_capture)
                       |=> dff_q == $past(dff_data))
      else $error("capture edge did not load data");
   a_tff_toggle:
      assert property (!(tff_clear_en && tff_clear) && $rose(tff_toggle)
                       |=> tff_q != $past(tff_q))
      else $error("toggle edge did not invert");
   a_sr_both_low:
      assert property (!restore_now && sr_set[0] && sr_reset[0]
                       |=> !sr_q[0])
      else $error("sr with both active not low");
   a_nv_change_write:
      assert property (changed && nv_state_reg == cmo_pkg::CMO_NV_IDLE
                       |=> ##[0:2] nv_wr_req)
      else $error("stored change not written");
   a_nv_bounded:
      assert property (nv_wr_req |-> nv_age_reg <= {1'b0, NV_LAST})
      else $error("nv write exceeded its time");

   c_cmp_signal: cover property (cmp_signal_mode && cmp_out);
   c_nv_write:   cover property ($rose(nv_wr_req) ##[1:20] nv_wr_ack);
   c_rm_latch:   cover property ($rose(rm_q));
   c_rmon_latch: cover property ($rose(rmon_q));

endmodule

// *** tb/test_comparator_and_memory_operators.sv ***
// Purpose: self-checking bench for the operator block
// Assumes: short nv and blink counts given at the instance
// Notes:   inputs driven at the rising edge, outputs read 1 ns later
`timescale 1ns/1ps

module test_comparator_and_memory_operators;
   logic              clk_sys = 1'h0, rst_b = 1'h0, b;
   logic [7:0]        cmp_bits = 8'h00, cmp_const = 8'h00, m, sr_q;
   logic [7:0]        sr_set = 8'h00, sr_reset = 8'h00, nv_wr_data;
   logic [7:0]        sr_store_en = 8'h00, sr_restore_data = 8'h00;
   logic [3:0]        cmp_count = 4'h0, operand_a = 4'h0, operand_b = 4'h0;
   logic              cmp_signal_mode = 1'h0, sr_restore_valid = 1'h0;
   logic              dff_preset = 1'h0, dff_clear = 1'h0, dff_data = 1'h0;
   logic              dff_capture = 1'h0, tff_toggle = 1'h0, tff_clear = 1'h0;
   logic              tff_clear_en = 1'h0, nv_wr_ack = 1'h0;
   logic              rl_clear_en = 1'h0, rl_clear = 1'h0;
   logic              rl_permit = 1'h0, rl_restart = 1'h0;
   logic              cmp_out, dff_q, tff_q, nv_wr_req, nv_wr_timeout;
   logic              nv_wr_worn, rm_q, rm_req1, rm_req2;
   logic              rmon_q, rmon_req1, rmon_req2;
   cmo_pkg::cmo_rel_e cmp_rel = cmo_pkg::CMO_LT;
   int                errors = 0, comparisons = 0;
   logic [7:0]        bv[5] = '{8'h96, 8'hFA, 8'h96, 8'h03, 8'h09};
   logic [7:0]        kv[5] = '{8'h96, 8'h1A, 8'hC8, 8'h09, 8'h09};
   logic [3:0]        nv[5] = '{4'h8, 4'h5, 4'h8, 4'h8, 4'h8};

   // block under test, both latches share their inputs
   cmo_top #(.SR_COUNT(8), .NV_WRITE_CYCLES(20),
             .BLINK_HALF_CYCLES(8)) u_dut (
      .clk_sys, .rst_b, .cmp_bits, .cmp_count, .cmp_const, .cmp_rel,
      .cmp_signal_mode, .operand_a, .operand_b, .cmp_out, .dff_preset,
      .dff_clear, .dff_capture, .dff_data, .dff_q, .tff_toggle,
      .tff_clear_en, .tff_clear, .tff_q, .sr_set, .sr_reset, .sr_store_en,
      .sr_restore_valid, .sr_restore_data, .sr_q, .nv_wr_ack, .nv_wr_req,
      .nv_wr_data, .nv_wr_timeout, .nv_wr_worn, .rm_clear_en(rl_clear_en),
      .rm_clear(rl_clear), .rm_permit(rl_permit), .rm_restart(rl_restart),
      .rm_q, .rm_req1, .rm_req2, .rmon_clear_en(rl_clear_en),
      .rmon_clear(rl_clear), .rmon_permit(rl_permit),
      .rmon_restart(rl_restart), .rmon_q, .rmon_req1, .rmon_req2);

   // 100 MHz clock
   always #5 clk_sys = ~clk_sys;

   // helpers: edge wait, compare, relation model, verdict
   task automatic e;
      @(posedge clk_sys);
   endtask
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   function automatic logic rel(input int r, input logic [7:0] x, y);
      case (r)
         0: return x < y;
         1: return x <= y;
         2: return x > y;
         3: return x >= y;
         4: return x == y;
         default: return x != y;
      endcase
   endfunction
   task automatic test_done;
      $display("errors=%0d comparisons=%0d", errors, comparisons);
      if (errors == 0 && comparisons > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // d and t flip-flop step: {pre,clr,cap,data}, {tog,clr_en,clr}
   task automatic ff(input logic [3:0] dv, tv, input logic [1:0] q);
      e;
      {dff_preset, dff_clear, dff_capture, dff_data} <= dv;
      {tff_toggle, tff_clear_en, tff_clear} <= tv[2:0];
      e;
      #1 check(dff_q, q[1]);
      check(tff_q, q[0]);
   endtask
   // latch step: {clr_en,clr,permit,restart}, {rm q,req1,rmon q,req1}
   task automatic rl(input logic [3:0] v, q);
      e;
      {rl_clear_en, rl_clear, rl_permit, rl_restart} <= v;
      e;
      #1 check({rm_q, rm_req1, rmon_q, rmon_req1}, q);
      if (!q[2]) check(rm_req2, !q[3]);
      if (!q[0]) check(rmon_req2, !q[1]);
   endtask

   // hang guard, far beyond the some 125 cycles needed
   initial begin
      #20000;
      errors++;
      test_done;
   end

   // main sequence
   initial begin
      repeat (20) e;
      rst_b <= 1'h1;
      sr_store_en <= 8'h03;
      sr_restore_data <= 8'h06;
      sr_restore_valid <= 1'h1;
      e;
      sr_restore_valid <= 1'h0;
      sr_set <= 8'h05;
      sr_reset <= 8'h04;
      #1 check(sr_q, 8'h02);
      e;
      #1 check(sr_q, 8'h03);
      repeat (2) e;
      #1 check(nv_wr_req, 1'h1);
      check(nv_wr_data, 8'h03);
      e;
      nv_wr_ack <= 1'h1;
      e;
      nv_wr_ack <= 1'h0;
      sr_set <= 8'h01;
      sr_reset <= 8'h01;
      e;
      #1 check(nv_wr_req, 1'h0);
      check(sr_q, 8'h02);
      ff(4'h8, 4'h4, 2'h3);
      ff(4'hC, 4'h0, 2'h1);
      ff(4'h1, 4'h4, 2'h0);
      ff(4'h3, 4'h0, 2'h2);
      ff(4'h2, 4'h4, 2'h3);
      ff(4'h0, 4'h1, 2'h3);
      ff(4'h2, 4'h3, 2'h0);
      for (int i = 0; i < 5; i++) begin
         for (int r = 0; r < 6; r++) begin
            e;
            {cmp_bits, cmp_count, cmp_const} <= {bv[i], nv[i], kv[i]};
            {operand_a, operand_b} <= {bv[i][3:0], kv[i][3:0]};
            cmp_signal_mode <= (i > 2);
            cmp_rel <= cmo_pkg::cmo_rel_e'(r);
            m = bv[i] & ((i > 2) ? 8'h0F : (8'h01 << nv[i]) - 8'h01);
            e;
            #1 check(cmp_out, rel(r, m, kv[i]));
         end
      end
      check(nv_wr_timeout, 1'h1);
      check(nv_wr_worn, 1'h0);
      rl(4'hE, 4'h0);
      rl(4'h2, 4'h5);
      b = rm_req2;
      repeat (8) e;
      #1 check(rm_req2, !b);
      rl(4'h3, 4'h9);
      rl(4'h2, 4'hA);
      rl(4'h6, 4'hA);
      rl(4'hE, 4'h0);
      rl(4'h3, 4'h9);
      rl(4'h1, 4'h0);
      test_done;
   end
endmodule
